// File: rtl/port_pkg.sv
// Package: register map, field widths and reset values for the port block
package port_pkg;
    localparam int unsigned PORT_WIDTH = 8;
    localparam int unsigned KEY_WIDTH  = 4;
    localparam int unsigned ADDR_WIDTH = 16;
    localparam int unsigned DATA_WIDTH = 32;
    localparam int unsigned IDX_WIDTH  = 14;

    // Register indices; byte address is four times the index
    localparam logic [IDX_WIDTH-1:0] IDX_OUTPUT_LATCH    = 14'h0004;
    localparam logic [IDX_WIDTH-1:0] IDX_PIN_STATE       = 14'h0011;
    localparam logic [IDX_WIDTH-1:0] IDX_DIRECTION       = 14'h0F1E;
    localparam logic [IDX_WIDTH-1:0] IDX_PULLUP_ENABLE   = 14'h0F2B;
    localparam logic [IDX_WIDTH-1:0] IDX_FUNCTION_SELECT = 14'h0F38;
    localparam logic [IDX_WIDTH-1:0] IDX_KEY_WAKEUP_CTRL = 14'h0F40;

    localparam logic [PORT_WIDTH-1:0] PORT_RESET = 8'h00;
    localparam logic [KEY_WIDTH-1:0]  KEY_RESET  = 4'h0;
    localparam logic [DATA_WIDTH-1:0] READ_ZERO  = 32'h0000_0000;
    localparam logic [1:0]            BYTE_LANE  = 2'h0;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_t;
endpackage : port_pkg

// File: rtl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync
    import port_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic [PORT_WIDTH-1:0] pin_async,
    output logic      [PORT_WIDTH-1:0] pin_level
);
    logic [PORT_WIDTH-1:0] stage1_r;
    logic [PORT_WIDTH-1:0] stage2_r;
    logic [PORT_WIDTH-1:0] stage3_r;
    logic [PORT_WIDTH-1:0] level_r;
    logic [PORT_WIDTH-1:0] level_nxt;

    // A change counts only once stages two and three agree
    always_comb begin
        level_nxt = level_r;
        for (int i = 0; i < PORT_WIDTH; i++) begin
            if (stage2_r[i] == stage3_r[i]) begin
                level_nxt[i] = stage3_r[i];
            end
        end
    end

    // Stage one feeds stage two only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage1_r <= PORT_RESET;
            stage2_r <= PORT_RESET;
            stage3_r <= PORT_RESET;
            level_r  <= PORT_RESET;
        end else begin
            stage1_r <= pin_async;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            level_r  <= level_nxt;
        end
    end

    assign pin_level = level_r;
endmodule : pin_sync

// File: rtl/port_analog_keywake.sv
// Eight-bit port with analog alternate function, key wakeup and pull-ups
//
// Summary of operation
// - Eight pins, each independently input or output.
// - Output pin follows latch bit; latch resets 0.
// - Pin state reads pin only when dir=fc=0.
// - Pull-up connects only for key wakeup or input.
// - Key wakeup on low pins overrides direction/function.
// - All pins analog capable; low four key wakeup.
// - Every pin has software pull-up toward supply.
`timescale 1ns/1ps
module port_analog_keywake
    import port_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic [ADDR_WIDTH-1:0] avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [DATA_WIDTH-1:0] avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [DATA_WIDTH-1:0] avs_readdata,
    output logic                       avs_waitrequest,
    input  wire logic [PORT_WIDTH-1:0] port_pin_in,
    output logic      [PORT_WIDTH-1:0] port_pin_out,
    output logic      [PORT_WIDTH-1:0] port_pin_oe,
    output logic      [PORT_WIDTH-1:0] pullup_connect,
    output logic      [PORT_WIDTH-1:0] analog_input_pin,
    output logic      [KEY_WIDTH-1:0]  key_wakeup_input
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [PORT_WIDTH-1:0] pin_level;
    bus_state_t            state_r;
    bus_state_t            state_nxt;
    logic                  wait_r;
    logic                  wait_nxt;
    logic [DATA_WIDTH-1:0] rdata_r;
    logic [DATA_WIDTH-1:0] rdata_nxt;
    logic [PORT_WIDTH-1:0] latch_r;
    logic [PORT_WIDTH-1:0] latch_nxt;
    logic [PORT_WIDTH-1:0] dir_r;
    logic [PORT_WIDTH-1:0] dir_nxt;
    logic [PORT_WIDTH-1:0] pu_r;
    logic [PORT_WIDTH-1:0] pu_nxt;
    logic [PORT_WIDTH-1:0] fsel_r;
    logic [PORT_WIDTH-1:0] fsel_nxt;
    logic [KEY_WIDTH-1:0]  kwen_r;
    logic [KEY_WIDTH-1:0]  kwen_nxt;
    logic [PORT_WIDTH-1:0] kwen_wide;
    logic [PORT_WIDTH-1:0] pin_state;
    logic [PORT_WIDTH-1:0] out_r;
    logic [PORT_WIDTH-1:0] out_nxt;
    logic [PORT_WIDTH-1:0] oe_r;
    logic [PORT_WIDTH-1:0] oe_nxt;
    logic [PORT_WIDTH-1:0] pull_r;
    logic [PORT_WIDTH-1:0] pull_nxt;
    logic [PORT_WIDTH-1:0] ana_r;
    logic [PORT_WIDTH-1:0] ana_nxt;
    logic [KEY_WIDTH-1:0]  key_r;
    logic [KEY_WIDTH-1:0]  key_nxt;
    logic [IDX_WIDTH-1:0]  idx;
    logic                  write_commit;

    // Byte address to register index; low two bits ignored
    function automatic logic [IDX_WIDTH-1:0] reg_index(input logic [ADDR_WIDTH-1:0] a);
        return a[ADDR_WIDTH-1:2];
    endfunction : reg_index

    // Plain port input: digital read and pull-up both allowed
    function automatic logic [PORT_WIDTH-1:0] plain_input(
        input logic [PORT_WIDTH-1:0] dir_bits,
        input logic [PORT_WIDTH-1:0] fsel_bits
    );
        return ~dir_bits & ~fsel_bits;
    endfunction : plain_input

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    pin_sync u_pin_sync (
        .clk       (clk),
        .reset     (reset),
        .pin_async (port_pin_in),
        .pin_level (pin_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // Key wakeup exists on the low pins only; upper enables tie low
    for (genvar g = 0; g < PORT_WIDTH; g++) begin : g_kwen
        if (g < KEY_WIDTH) begin : g_low
            assign kwen_wide[g] = kwen_r[g];
        end else begin : g_high
            assign kwen_wide[g] = 1'b0;
        end
    end

    // Pin-state view; blocked pins read zero
    assign pin_state = pin_level & plain_input(dir_r, fsel_r);
    assign idx       = reg_index(avs_address);

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, then an acknowledge cycle
    always_comb begin
        state_nxt = state_r;
        wait_nxt  = wait_r;
        rdata_nxt = rdata_r;
        unique case (state_r)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    state_nxt = BUS_ACK;
                    wait_nxt  = 1'b0;
                    rdata_nxt = READ_ZERO;
                    // Unmapped indices read zero
                    unique case (idx)
                        IDX_OUTPUT_LATCH:    rdata_nxt[PORT_WIDTH-1:0] = latch_r;
                        IDX_PIN_STATE:       rdata_nxt[PORT_WIDTH-1:0] = pin_state;
                        IDX_DIRECTION:       rdata_nxt[PORT_WIDTH-1:0] = dir_r;
                        IDX_PULLUP_ENABLE:   rdata_nxt[PORT_WIDTH-1:0] = pu_r;
                        IDX_FUNCTION_SELECT: rdata_nxt[PORT_WIDTH-1:0] = fsel_r;
                        IDX_KEY_WAKEUP_CTRL: rdata_nxt[KEY_WIDTH-1:0]  = kwen_r;
                        default:             rdata_nxt = READ_ZERO;
                    endcase
                end
            end
            BUS_ACK: begin
                state_nxt = BUS_IDLE;
                wait_nxt  = 1'b1;
            end
            default: begin
                state_nxt = BUS_IDLE;
                wait_nxt  = 1'b1;
            end
        endcase
    end

    // Handshake state; waitrequest idles high through reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= BUS_IDLE;
            wait_r  <= 1'b1;
            rdata_r <= READ_ZERO;
        end else begin
            state_r <= state_nxt;
            wait_r  <= wait_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file
    // Write commits on the edge where waitrequest is seen low
    assign write_commit = (state_r == BUS_ACK) && avs_write && avs_byteenable[BYTE_LANE];

    // Pin-state and unmapped indices swallow the write
    always_comb begin
        latch_nxt = latch_r;
        dir_nxt   = dir_r;
        pu_nxt    = pu_r;
        fsel_nxt  = fsel_r;
        kwen_nxt  = kwen_r;
        if (write_commit) begin
            unique case (idx)
                IDX_OUTPUT_LATCH:    latch_nxt = avs_writedata[PORT_WIDTH-1:0];
                IDX_DIRECTION:       dir_nxt   = avs_writedata[PORT_WIDTH-1:0];
                IDX_PULLUP_ENABLE:   pu_nxt    = avs_writedata[PORT_WIDTH-1:0];
                IDX_FUNCTION_SELECT: fsel_nxt  = avs_writedata[PORT_WIDTH-1:0];
                IDX_KEY_WAKEUP_CTRL: kwen_nxt  = avs_writedata[KEY_WIDTH-1:0];
                default:             latch_nxt = latch_r;
            endcase
        end
    end

    // Registers all clear so every pin starts as an undriven input
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            latch_r <= PORT_RESET;
            dir_r   <= PORT_RESET;
            pu_r    <= PORT_RESET;
            fsel_r  <= PORT_RESET;
            kwen_r  <= KEY_RESET;
        end else begin
            latch_r <= latch_nxt;
            dir_r   <= dir_nxt;
            pu_r    <= pu_nxt;
            fsel_r  <= fsel_nxt;
            kwen_r  <= kwen_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pad controls; registered so outputs never glitch on decode
    always_comb begin
        out_nxt  = latch_r;
        // Key wakeup wins so a stray direction bit cannot fight the key
        oe_nxt   = dir_r & ~fsel_r & ~kwen_wide;
        pull_nxt = pu_r & (kwen_wide | plain_input(dir_r, fsel_r));
        ana_nxt  = fsel_r & ~dir_r & ~kwen_wide;
        key_nxt  = pin_level[KEY_WIDTH-1:0] & kwen_r;
    end

    // Pad registers; all low in reset so no pin is driven
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_r  <= PORT_RESET;
            oe_r   <= PORT_RESET;
            pull_r <= PORT_RESET;
            ana_r  <= PORT_RESET;
            key_r  <= KEY_RESET;
        end else begin
            out_r  <= out_nxt;
            oe_r   <= oe_nxt;
            pull_r <= pull_nxt;
            ana_r  <= ana_nxt;
            key_r  <= key_nxt;
        end
    end

    // Every output comes straight from a flip-flop
    assign avs_readdata     = rdata_r;
    assign avs_waitrequest  = wait_r;
    assign port_pin_out     = out_r;
    assign port_pin_oe      = oe_r;
    assign pullup_connect   = pull_r;
    assign analog_input_pin = ana_r;
    assign key_wakeup_input = key_r;
endmodule : port_analog_keywake

// File: verif/port_checker.sv
// Checker: bus handshake and pad relations of the port block
`timescale 1ns/1ps
module port_checker
    import port_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  reset,
    input wire logic [ADDR_WIDTH-1:0] avs_address,
    input wire logic                  avs_read,
    input wire logic                  avs_write,
    input wire logic [DATA_WIDTH-1:0] avs_writedata,
    input wire logic [3:0]            avs_byteenable,
    input wire logic [DATA_WIDTH-1:0] avs_readdata,
    input wire logic                  avs_waitrequest,
    input wire logic [PORT_WIDTH-1:0] port_pin_in,
    input wire logic [PORT_WIDTH-1:0] port_pin_out,
    input wire logic [PORT_WIDTH-1:0] port_pin_oe,
    input wire logic [PORT_WIDTH-1:0] pullup_connect,
    input wire logic [PORT_WIDTH-1:0] analog_input_pin,
    input wire logic [KEY_WIDTH-1:0]  key_wakeup_input
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Handshake: one wait cycle, one-cycle acknowledge, no ack without request
    chk_ack_one_wait: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("ack late");
    chk_ack_single: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("ack held");
    chk_idle_wait: assert property (
        !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
        else $error("ack unasked");
    // Latch commits at the ack edge, pad register follows one edge later
    chk_out_by_write: assert property (
        !$stable(port_pin_out) |-> $past(avs_write && !avs_waitrequest, 2))
        else $error("pad moved");
    chk_latch_pad: assert property (
        avs_write && !avs_waitrequest && avs_byteenable[BYTE_LANE]
        && avs_address[15:2] == IDX_OUTPUT_LATCH
        |=> ##1 port_pin_out == $past(avs_writedata[PORT_WIDTH-1:0], 2))
        else $error("latch not on pad");
    chk_oe_analog: assert property (
        (port_pin_oe & analog_input_pin) == 8'h00)
        else $error("oe and analog");
    chk_pull_drive: assert property (
        (pullup_connect & port_pin_oe) == 8'h00)
        else $error("pull-up on output");
    chk_pull_analog: assert property (
        (pullup_connect & analog_input_pin) == 8'h00)
        else $error("pull-up on analog");
    chk_key_drive: assert property (
        (key_wakeup_input & port_pin_oe[3:0]) == 4'h0)
        else $error("key pin driven");
    // Driven and analog pins read zero in the pin-state answer
    chk_state_block: assert property (
        !avs_waitrequest && $past(avs_read && avs_address[15:2] == IDX_PIN_STATE)
        |-> (avs_readdata & {24'h000000, port_pin_oe | analog_input_pin}) == 32'h00000000)
        else $error("blocked pin read");
endmodule : port_checker

bind port_analog_keywake port_checker chk_i (.clk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .port_pin_in, .port_pin_out,
    .port_pin_oe, .pullup_connect, .analog_input_pin, .key_wakeup_input);

// File: verif/port_analog_keywake_tb.sv
// Testbench: registers, pin-state reads and pad outputs of the port block
`timescale 1ns/1ps
module port_analog_keywake_tb
    import port_pkg::*;
;
    logic                  clk, reset, avs_read, avs_write, avs_waitrequest;
    logic [ADDR_WIDTH-1:0] avs_address;
    logic [DATA_WIDTH-1:0] avs_writedata, avs_readdata;
    logic [3:0]            avs_byteenable;
    logic [PORT_WIDTH-1:0] port_pin_in, port_pin_out, port_pin_oe;
    logic [PORT_WIDTH-1:0] pullup_connect, analog_input_pin;
    logic [KEY_WIDTH-1:0]  key_wakeup_input, kw;
    logic [7:0]            lat, dir, fs, pu, pin;
    logic [31:0]           exp_q[$];
    int                    num_errors = 0, comparisons = 0, cycles = 0, seed = 20718;

    port_analog_keywake DUT (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .port_pin_in, .port_pin_out,
        .port_pin_oe, .pullup_connect, .analog_input_pin, .key_wakeup_input);

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic test_done;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done

    // Holds the request until waitrequest is sampled low, then one idle edge
    task automatic bus(input logic [13:0] i, input logic w, input logic [7:0] d,
                       input logic [3:0] b);
        avs_address <= {i, BYTE_LANE};
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= {24'hA5A5A5, d};
        avs_byteenable <= b;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic rd(input logic [13:0] i, input logic [7:0] e);
        exp_q.push_back({24'h000000, e});
        bus(i, 1'b0, 8'h00, 4'hF);
    endtask : rd

    // Register readback and pad state from the bench's own copy
    task automatic regs;
        rd(IDX_OUTPUT_LATCH, lat);
        rd(IDX_DIRECTION, dir);
        rd(IDX_FUNCTION_SELECT, fs);
        rd(IDX_PULLUP_ENABLE, pu);
        rd(IDX_KEY_WAKEUP_CTRL, {4'h0, kw});
        rd(IDX_PIN_STATE, pin & ~dir & ~fs);
        rd(14'h0100, 8'h00);
        check(32'(port_pin_out), 32'(lat));
        check(32'(port_pin_oe), 32'(dir & ~fs & ~{4'h0, kw}));
        check(32'(pullup_connect), 32'(pu & ({4'h0, kw} | (~dir & ~fs))));
        check(32'(analog_input_pin), 32'(fs & ~dir & ~{4'h0, kw}));
        check(32'(key_wakeup_input), 32'(pin[3:0] & kw));
    endtask : regs

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Result watcher, plus a hang guard well above the expected run
    always @(posedge clk) begin
        cycles++;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
            check(avs_readdata, exp_q.pop_front());
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end

    initial begin
        {lat, dir, fs, pu, kw} = '0;
        pin = 8'($random(seed));
        {reset, avs_read, avs_write} = 3'h4;
        {avs_address, avs_writedata, avs_byteenable} = '0;
        port_pin_in = pin;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        regs();
        // Random settings; refused writes must leave state alone
        repeat (12) begin
            {lat, dir, fs, pu, kw, pin} = 44'({$random(seed), $random(seed)});
            port_pin_in <= pin;
            bus(IDX_OUTPUT_LATCH, 1'b1, lat, 4'h1);
            bus(IDX_DIRECTION, 1'b1, dir, 4'h1);
            bus(IDX_FUNCTION_SELECT, 1'b1, fs, 4'h1);
            bus(IDX_PULLUP_ENABLE, 1'b1, pu, 4'h1);
            bus(IDX_KEY_WAKEUP_CTRL, 1'b1, {4'h0, kw}, 4'h1);
            bus(IDX_PIN_STATE, 1'b1, ~pin, 4'h1);
            bus(IDX_OUTPUT_LATCH, 1'b1, ~lat, 4'hE);
            bus(14'h0100, 1'b1, 8'hFF, 4'h1);
            regs();
        end
        // Reset in mid-run clears every register and pad
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        {lat, dir, fs, pu, kw} = '0;
        @(posedge clk);
        regs();
        test_done();
    end
endmodule : port_analog_keywake_tb
